// file: isg_fetch_model.sv
// Fetch-side model that hands decode-stage words to the gate
`timescale 1ns/10ps
`default_nettype none
module isg_fetch_model (
   input  wire logic        clk_sys,
   output logic             in_valid,
   output logic [31:0]      in_insn
);
   initial begin
      in_valid = 1'b0;
      in_insn  = 32'h0;
   end
   // Idle gaps model a slow fetch; released word is inverted, never stale
   task automatic send(input logic [31:0] w, input int gap);
      repeat (gap) @(posedge clk_sys);
      @(posedge clk_sys);
      in_valid <= 1'b1;
      in_insn  <= w;
      @(posedge clk_sys);
      in_valid <= 1'b0;
      in_insn  <= ~w;
   endtask
endmodule
`default_nettype wire

// file: isg_gate.sv
// Decode-stage gate that traps instructions the implementation omits
// Operation
// (RQ1) All plain integer instructions always pass
// (RQ2) Omitted instruction raises exception, never executes
// (RQ3) No FPU drops FPU branches and moves
// (RQ4) Single-only FPU: release 6, mode 0
// (RQ5) Release 6 wide FPU forces mode 1
// (RQ6) Release 6 never reports paired single
// (RQ7) Pre-release-5 wide FPU: mode 0 required; the gate still lets mode_wr select mode 1
// (RQ8) Release 5 wide FPU: both modes selectable
// (RQ9) Virtualization or SIMD implies release 5
// (RQ10) Coprocessor 2 optional, per-instruction omission
// (RQ11) Cache presence shown in own fields
// (RQ12) Reserved fields carry no meaning
// (RQ13) Optional modules reported, whole or subset
// (RQ14) No debug: breakpoint and return trap
// (RQ15) Mode-switch jump only with mode switching
// (RQ16) Both encodings share one width
// (RQ17) User extension opcode reserved from release 6
// (RQ18) Third coprocessor opcode always reserved
// (RQ19) Absent unit unusable, else reserved
`timescale 1ns/10ps
`default_nettype none
module isg_gate
   import isg_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic                 ce,
   input  wire isg_pkg::isg_rel_t    cfg_release,
   input  wire isg_pkg::isg_fpu_t    cfg_fpu,
   input  wire logic                 cfg_virt_ext,
   input  wire logic                 cfg_simd_ext,
   input  wire logic                 cfg_cp2,
   input  wire logic [9:0]           cfg_cp2_omit,
   input  wire logic                 cfg_icache,
   input  wire logic                 cfg_dcache,
   input  wire logic                 cfg_debug,
   input  wire logic                 cfg_std_enc,
   input  wire logic                 cfg_cmp_enc,
   input  wire logic                 cfg_mode16,
   input  wire logic                 cfg_wide,
   input  wire logic                 cfg_cmp_wide,
   input  wire logic                 cfg_user_ext,
   input  wire logic                 mode_wr,
   input  wire logic                 mode_wr_val,
   input  wire logic                 in_valid,
   input  wire logic [31:0]          in_insn,
   output logic                      out_valid,
   output logic [31:0]               out_insn,
   output isg_pkg::isg_exc_t         out_exc,
   output logic [1:0]                out_exc_unit,
   output logic                      float_unit_present_bit,
   output logic                      second_coproc_present_bit,
   output logic                      instr_cache_info_field,
   output logic                      data_cache_info_field,
   output logic                      float_reg_width_mode,
   output logic                      single_format_flag,
   output logic                      double_format_flag,
   output logic                      long_format_flag,
   output logic                      paired_single_flag,
   output logic                      wide_float_regs_flag,
   output logic                      virt_ext_flag,
   output logic                      simd_ext_flag,
   output logic                      debug_present_flag,
   output logic                      cfg_error
);
   import isg_pkg::*;

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic              valid;
      logic [31:0]       insn;
      isg_exc_t          exc;
      logic [1:0]        unit;
      logic              fr;
      logic              fp;
      logic              cp2;
      logic              ic;
      logic              dc;
      logic              fs;
      logic              fd;
      logic              fl;
      logic              fps;
      logic              f64;
      logic              virt;
      logic              simd;
      logic              dbg;
      logic              err;
   } isg_state_t;

   isg_state_t s_q;
   isg_state_t s_d;

   // ***************************************************************
   // Effective feature set
   // ***************************************************************
   logic      rel5_up;
   logic      rel6;
   logic      fpu_on;
   logic      fpu_wide;
   logic      fpu_ps;
   logic      fr_fixed1;
   logic      fr_fixed0;
   logic      bad_cfg;
   logic [5:0] op;
   logic [4:0] rs;
   logic [5:0] fn;

   assign op = in_insn[ISG_OP_HI:ISG_OP_LO];
   assign rs = in_insn[ISG_RS_HI:ISG_RS_LO];
   assign fn = in_insn[ISG_FN_HI:ISG_FN_LO];

   // Extensions lift the release floor rather than trusting the strap
   assign rel5_up = (cfg_release >= ISG_REL5) | cfg_virt_ext
                    | cfg_simd_ext; // RQ9
   assign rel6    = (cfg_release == ISG_REL6);
   assign fpu_on  = (cfg_fpu != ISG_FPU_NONE); // RQ3
   assign fpu_wide = (cfg_fpu == ISG_FPU_64) | (cfg_fpu == ISG_FPU_64PS);
   // Paired single is stripped in release 6 even if strapped
   assign fpu_ps  = (cfg_fpu == ISG_FPU_64PS) & ~rel6; // RQ6
   // Release 6 wide unit cannot run mode 0
   assign fr_fixed1 = rel6 & fpu_wide; // RQ5
   // Single-only unit and pre-release-5 without mode 1 stay in mode 0
   assign fr_fixed0 = (cfg_fpu == ISG_FPU_32) // RQ4
                      | (fpu_wide & ~rel5_up & ~rel6 & ~cfg_fr1_cap());

   function automatic logic cfg_fr1_cap();
      cfg_fr1_cap = 1'b1; // RQ7
   endfunction

   // Straps that break RQ4, RQ16 or RQ6 are flagged, not hidden
   assign bad_cfg = ((cfg_fpu == ISG_FPU_32) & ~rel6) // RQ4
                  | (cfg_std_enc & cfg_cmp_enc
                     & (cfg_wide != cfg_cmp_wide)) // RQ16
                  | (rel6 & (cfg_fpu == ISG_FPU_64PS)); // RQ6

   // ***************************************************************
   // Decode classification
   // ***************************************************************
   isg_exc_t  exc;
   logic [1:0] unit;
   logic       is_fpu;
   logic       is_cp2;
   logic       cp2_omit;
   logic       mjump_ok;

   assign is_fpu = (op == ISG_OP_COP1) | (op == ISG_OP_LWC1)
                 | (op == ISG_OP_LDC1) | (op == ISG_OP_SWC1)
                 | (op == ISG_OP_SDC1)
                 | ((op == ISG_OP_SPECIAL) & (fn == ISG_FN_MOVCI)
                    & ~rel6); // RQ3
   assign is_cp2 = (op == ISG_OP_CP2)
                  | (~rel6 & ((op == ISG_OP_LWC2) | (op == ISG_OP_LDC2)
                  | (op == ISG_OP_SWC2) | (op == ISG_OP_SDC2)));
   assign mjump_ok = ~rel6 & ((cfg_std_enc & cfg_cmp_enc)
                    | cfg_mode16); // RQ15

   // Per-instruction coprocessor 2 omission lookup
   always_comb begin
      cp2_omit = 1'b0;
      unique case (op)
         ISG_OP_LWC2: cp2_omit = cfg_cp2_omit[ISG_CP2_LW];
         ISG_OP_LDC2: cp2_omit = cfg_cp2_omit[ISG_CP2_LD];
         ISG_OP_SWC2: cp2_omit = cfg_cp2_omit[ISG_CP2_SW];
         ISG_OP_SDC2: cp2_omit = cfg_cp2_omit[ISG_CP2_SD];
         ISG_OP_CP2: begin
            if (rs[4]) begin
               cp2_omit = cfg_cp2_omit[ISG_CP2_CO];
            end else if (rs == ISG_RS_MF) begin
               cp2_omit = cfg_cp2_omit[ISG_CP2_MF];
            end else if (rs == ISG_RS_CF) begin
               cp2_omit = cfg_cp2_omit[ISG_CP2_CF];
            end else if (rs == ISG_RS_MT) begin
               cp2_omit = cfg_cp2_omit[ISG_CP2_MT];
            end else if (rs == ISG_RS_CT) begin
               cp2_omit = cfg_cp2_omit[ISG_CP2_CT];
            end else if (rs == ISG_RS_BC) begin
               cp2_omit = cfg_cp2_omit[ISG_CP2_BC];
            end
         end
         default: cp2_omit = 1'b0;
      endcase
   end

   // Priority: absent unit first, then omitted or reserved encodings.
   // Integer opcodes not listed below always pass untouched.
   always_comb begin
      exc  = ISG_EXC_NONE; // RQ1
      unit = 2'h0;
      if (is_fpu & ~fpu_on) begin
         exc  = ISG_EXC_CPU; // RQ19
         unit = 2'h1;
      end else if (is_cp2 & ~cfg_cp2) begin
         exc  = ISG_EXC_CPU; // RQ10
         unit = 2'h2;
      end else if (is_cp2 & cp2_omit) begin
         exc  = ISG_EXC_RI; // RQ10
      end else if (op == ISG_OP_CP3) begin
         exc  = ISG_EXC_RI; // RQ18
      end else if ((op == ISG_OP_USREXT) & (rel6 | ~cfg_user_ext)) begin
         exc  = ISG_EXC_RI; // RQ17
      end else if ((op == ISG_OP_MJUMP) & ~mjump_ok) begin
         exc  = ISG_EXC_RI; // RQ15
      end else if ((op == ISG_OP_SPECIAL) & (fn == ISG_FN_DBGBRK)
                   & ~cfg_debug) begin
         exc  = ISG_EXC_RI; // RQ14
      end else if ((op == ISG_OP_COP0) & (rs[4] == ISG_RS_CO[4])
                   & (fn == ISG_FN_DBGRET) & ~cfg_debug) begin
         exc  = ISG_EXC_RI; // RQ14
      end
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      if (ce) begin
         s_d.valid = in_valid;
         // Trapped words still travel; execute must honour exc
         s_d.insn  = in_insn; // RQ2
         s_d.exc   = in_valid ? exc : ISG_EXC_NONE; // RQ2
         s_d.unit  = in_valid ? unit : 2'h0;
         s_d.fp    = fpu_on; // RQ3
         s_d.cp2   = cfg_cp2; // RQ10
         s_d.ic    = cfg_icache; // RQ11
         s_d.dc    = cfg_dcache; // RQ11
         s_d.fs    = fpu_on; // RQ4
         s_d.fd    = fpu_wide; // RQ4
         s_d.fl    = fpu_wide; // RQ4
         s_d.fps   = fpu_ps; // RQ6
         s_d.f64   = fpu_wide & (rel5_up | rel6); // RQ5
         s_d.virt  = cfg_virt_ext; // RQ13
         s_d.simd  = cfg_simd_ext; // RQ13
         s_d.dbg   = cfg_debug; // RQ13
         s_d.err   = bad_cfg;
         // Width mode: forced where fixed, otherwise software chooses
         if (~fpu_on | fr_fixed0) begin
            s_d.fr = 1'b0; // RQ4
         end else if (fr_fixed1) begin
            s_d.fr = 1'b1; // RQ5
         end else if (mode_wr) begin
            s_d.fr = mode_wr_val; // RQ8
         end
      end
   end

   // Register the whole state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign out_valid                 = s_q.valid;
   assign out_insn                  = s_q.insn;
   assign out_exc                   = s_q.exc;
   assign out_exc_unit              = s_q.unit;
   assign float_unit_present_bit    = s_q.fp;
   assign second_coproc_present_bit = s_q.cp2;
   assign instr_cache_info_field    = s_q.ic;
   assign data_cache_info_field     = s_q.dc;
   assign float_reg_width_mode      = s_q.fr;
   assign single_format_flag        = s_q.fs;
   assign double_format_flag        = s_q.fd;
   assign long_format_flag          = s_q.fl;
   assign paired_single_flag        = s_q.fps;
   assign wide_float_regs_flag      = s_q.f64;
   assign virt_ext_flag             = s_q.virt;
   assign simd_ext_flag             = s_q.simd;
   assign debug_present_flag        = s_q.dbg;
   assign cfg_error                 = s_q.err; // RQ12
endmodule
`default_nettype wire

// file: isg_gate_checker.sv
// Port-level assertions for the instruction subset gate
`timescale 1ns/10ps
`default_nettype none
module isg_gate_checker
   import isg_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        ce,
   input wire isg_rel_t    cfg_release,
   input wire isg_fpu_t    cfg_fpu,
   input wire logic        cfg_cp2,
   input wire logic        cfg_std_enc,
   input wire logic        cfg_cmp_enc,
   input wire logic        cfg_mode16,
   input wire logic        mode_wr,
   input wire logic        mode_wr_val,
   input wire logic        in_valid,
   input wire logic [31:0] in_insn,
   input wire logic        out_valid,
   input wire logic [31:0] out_insn,
   input wire isg_exc_t    out_exc,
   input wire logic [1:0]  out_exc_unit,
   input wire logic        float_unit_present_bit,
   input wire logic        float_reg_width_mode,
   input wire logic        paired_single_flag,
   input wire logic        wide_float_regs_flag,
   input wire logic        cfg_error
);
   import isg_pkg::*;
   // ****************
   // Helpers
   // ****************
   logic [5:0] opc;
   logic       tk;
   logic       up_q;
   assign opc = in_insn[31:26];
   assign tk  = ce && in_valid;
   // Status is only meaningful one clean edge after reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         up_q <= 1'b0;
      end else begin
         up_q <= ce;
      end
   end
   // ****************
   // Assertions
   // ****************
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (rst);
   pass_thru_a: assert property (tk |=> out_valid && out_insn == $past(in_insn))
      else $error("word not passed through");
   no_fpu_flag_a: assert property (up_q &&
      $past(cfg_fpu) == ISG_FPU_NONE |-> !float_unit_present_bit)
      else $error("absent unit shown");
   fpu_unusable_a: assert property (tk && cfg_fpu == ISG_FPU_NONE &&
      opc == ISG_OP_COP1 |=> out_exc == ISG_EXC_CPU && out_exc_unit == 2'h1)
      else $error("float op not unusable");
   cp2_unusable_a: assert property (tk && !cfg_cp2 && opc == ISG_OP_CP2
      |=> out_exc == ISG_EXC_CPU && out_exc_unit == 2'h2)
      else $error("coprocessor 2 op not unusable");
   cp3_resv_a: assert property (tk && cfg_release != ISG_REL1 &&
      opc == ISG_OP_CP3 |=> out_exc == ISG_EXC_RI) else $error("cp3 taken");
   usrext_resv_a: assert property (tk && cfg_release == ISG_REL6 &&
      opc == ISG_OP_USREXT |=> out_exc == ISG_EXC_RI) else $error("ext taken");
   mjump_kept_a: assert property (tk && cfg_release != ISG_REL6 &&
      (cfg_std_enc && cfg_cmp_enc || cfg_mode16) && opc == ISG_OP_MJUMP
      |=> out_exc == ISG_EXC_NONE) else $error("mode jump trapped");
   wide_mode_a: assert property (up_q && $past(cfg_release) == ISG_REL6 &&
      $past(cfg_fpu) == ISG_FPU_64 |-> float_reg_width_mode &&
      wide_float_regs_flag) else $error("wide unit not in mode 1");
   paired_off_a: assert property (up_q && $past(cfg_release) == ISG_REL6
      |-> !paired_single_flag) else $error("paired flag in release 6");
   mode_write_a: assert property (ce && mode_wr &&
      cfg_release == ISG_REL5 && cfg_fpu == ISG_FPU_64
      |=> float_reg_width_mode == $past(mode_wr_val)) else $error("mode lost");
   cover property (tk && opc == ISG_OP_COP1);
   cover property (ce && mode_wr);
   cover property (cfg_error);
   cover property (!ce && mode_wr);
endmodule
bind isg_gate isg_gate_checker i_isg_gate_checker (.clk_sys(clk_sys),
   .rst(rst), .ce(ce), .cfg_release(cfg_release), .cfg_fpu(cfg_fpu),
   .cfg_cp2(cfg_cp2), .cfg_std_enc(cfg_std_enc), .cfg_cmp_enc(cfg_cmp_enc),
   .cfg_mode16(cfg_mode16), .mode_wr(mode_wr), .mode_wr_val(mode_wr_val),
   .in_valid(in_valid), .in_insn(in_insn), .out_valid(out_valid),
   .out_insn(out_insn), .out_exc(out_exc), .out_exc_unit(out_exc_unit),
   .float_unit_present_bit(float_unit_present_bit),
   .float_reg_width_mode(float_reg_width_mode),
   .paired_single_flag(paired_single_flag),
   .wide_float_regs_flag(wide_float_regs_flag), .cfg_error(cfg_error));
`default_nettype wire

// file: isg_pkg.sv
// Package: constants for the instruction subset gate
package isg_pkg;
   // Architecture releases
   typedef enum logic [2:0] {
      ISG_REL1 = 3'h1,
      ISG_REL2 = 3'h2,
      ISG_REL3 = 3'h3,
      ISG_REL5 = 3'h5,
      ISG_REL6 = 3'h6
   } isg_rel_t;

   // Floating-point configurations
   typedef enum logic [1:0] {
      ISG_FPU_NONE = 2'h0,
      ISG_FPU_32   = 2'h1,
      ISG_FPU_64   = 2'h2,
      ISG_FPU_64PS = 2'h3
   } isg_fpu_t;

   // Decode outcome
   typedef enum logic [1:0] {
      ISG_EXC_NONE = 2'h0,
      ISG_EXC_RI   = 2'h1,
      ISG_EXC_CPU  = 2'h2
   } isg_exc_t;

   // Instruction field positions and encodings
   localparam int          ISG_OP_HI      = 31;
   localparam int          ISG_OP_LO      = 26;
   localparam int          ISG_RS_HI      = 25;
   localparam int          ISG_RS_LO      = 21;
   localparam int          ISG_FN_HI      = 5;
   localparam int          ISG_FN_LO      = 0;
   localparam logic [5:0]  ISG_OP_SPECIAL = 6'h00;
   localparam logic [5:0]  ISG_OP_MJUMP   = 6'h1d;
   localparam logic [5:0]  ISG_OP_COP0    = 6'h10;
   localparam logic [5:0]  ISG_OP_COP1    = 6'h11;
   localparam logic [5:0]  ISG_OP_CP2     = 6'h12;
   localparam logic [5:0]  ISG_OP_CP3     = 6'h13;
   localparam logic [5:0]  ISG_OP_USREXT  = 6'h1c;
   localparam logic [5:0]  ISG_OP_LWC1    = 6'h31;
   localparam logic [5:0]  ISG_OP_LWC2    = 6'h32;
   localparam logic [5:0]  ISG_OP_LDC1    = 6'h35;
   localparam logic [5:0]  ISG_OP_LDC2    = 6'h36;
   localparam logic [5:0]  ISG_OP_SWC1    = 6'h39;
   localparam logic [5:0]  ISG_OP_SWC2    = 6'h3a;
   localparam logic [5:0]  ISG_OP_SDC1    = 6'h3d;
   localparam logic [5:0]  ISG_OP_SDC2    = 6'h3e;
   localparam logic [5:0]  ISG_FN_MOVCI   = 6'h01;
   localparam logic [5:0]  ISG_FN_DBGBRK  = 6'h3f;
   localparam logic [5:0]  ISG_FN_DBGRET  = 6'h1f;
   localparam logic [4:0]  ISG_RS_BC1     = 5'h08;
   localparam logic [4:0]  ISG_RS_BC1EQZ  = 5'h09;
   localparam logic [4:0]  ISG_RS_BC1NEZ  = 5'h0d;
   localparam logic [4:0]  ISG_RS_CO      = 5'h10;
   // Pass a decode-stage instruction through in this many cycles
   localparam int          ISG_LATENCY    = 1;
   // Per-instruction coprocessor 2 omission mask bit positions
   localparam int          ISG_CP2_BC     = 0;
   localparam int          ISG_CP2_CF     = 1;
   localparam int          ISG_CP2_CO     = 2;
   localparam int          ISG_CP2_CT     = 3;
   localparam int          ISG_CP2_LD     = 4;
   localparam int          ISG_CP2_LW     = 5;
   localparam int          ISG_CP2_MF     = 6;
   localparam int          ISG_CP2_MT     = 7;
   localparam int          ISG_CP2_SD     = 8;
   localparam int          ISG_CP2_SW     = 9;
   localparam int          ISG_CP2_N      = 10;
   localparam logic [4:0]  ISG_RS_MF      = 5'h00;
   localparam logic [4:0]  ISG_RS_CF      = 5'h02;
   localparam logic [4:0]  ISG_RS_MT      = 5'h04;
   localparam logic [4:0]  ISG_RS_CT      = 5'h06;
   localparam logic [4:0]  ISG_RS_BC      = 5'h08;
endpackage

// file: tb_top.sv
// Self-checking bench for the instruction subset gate
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import isg_pkg::*;
   // ****************
   // Signals
   // ****************
   logic        clk_sys, rst, ce, mode_wr, mode_wr_val, in_valid, out_valid;
   logic [11:0] fl;  // virt simd cp2 ic dc dbg std cmp m16 wide cwide uext
   logic [13:0] st;  // fp c2 ic dc mode s d l ps f64 virt simd dbg err
   logic [9:0]  cfg_cp2_omit;
   logic [1:0]  out_exc_unit;
   logic [31:0] in_insn, out_insn;
   isg_rel_t    cfg_release;
   isg_fpu_t    cfg_fpu;
   isg_exc_t    out_exc;
   int          num_errors, total_checks;
   localparam logic [31:0] ADDIU = 32'h24010005;
   localparam logic [31:0] DBG_RETURN =
      {ISG_OP_COP0, 1'b1, 19'h0, ISG_FN_DBGRET};
   localparam logic [31:0] DBG_BREAK = {ISG_OP_SPECIAL, 20'h0, ISG_FN_DBGBRK};
   localparam logic [31:0] MOVCI = {ISG_OP_SPECIAL, 20'h0, ISG_FN_MOVCI};

   isg_fetch_model i_isg_fetch_model (.clk_sys(clk_sys), .in_valid(in_valid),
      .in_insn(in_insn));
   isg_gate i_isg_gate (.clk_sys(clk_sys), .rst(rst), .ce(ce),
      .cfg_release(cfg_release), .cfg_fpu(cfg_fpu), .cfg_virt_ext(fl[11]),
      .cfg_simd_ext(fl[10]), .cfg_cp2(fl[9]), .cfg_cp2_omit(cfg_cp2_omit),
      .cfg_icache(fl[8]), .cfg_dcache(fl[7]), .cfg_debug(fl[6]),
      .cfg_std_enc(fl[5]), .cfg_cmp_enc(fl[4]), .cfg_mode16(fl[3]),
      .cfg_wide(fl[2]), .cfg_cmp_wide(fl[1]), .cfg_user_ext(fl[0]),
      .mode_wr(mode_wr), .mode_wr_val(mode_wr_val), .in_valid(in_valid),
      .in_insn(in_insn), .out_valid(out_valid), .out_insn(out_insn),
      .out_exc(out_exc), .out_exc_unit(out_exc_unit),
      .float_unit_present_bit(st[13]), .second_coproc_present_bit(st[12]),
      .instr_cache_info_field(st[11]), .data_cache_info_field(st[10]),
      .float_reg_width_mode(st[9]), .single_format_flag(st[8]),
      .double_format_flag(st[7]), .long_format_flag(st[6]),
      .paired_single_flag(st[5]), .wide_float_regs_flag(st[4]),
      .virt_ext_flag(st[3]), .simd_ext_flag(st[2]),
      .debug_present_flag(st[1]), .cfg_error(st[0]));

   // ****************
   // Shared tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Straps change at an edge; the next word also refreshes the status
   task automatic cfg(input isg_rel_t r, input isg_fpu_t f,
                      input logic [11:0] b, input logic [9:0] om);
      @(posedge clk_sys);
      cfg_release <= r;
      cfg_fpu <= f;
      fl <= b;
      cfg_cp2_omit <= om;
   endtask
   // Answer stands from the taking edge and is checked 1 ns after it
   task automatic run(input logic [31:0] w, input isg_exc_t e,
                      input logic [1:0] u);
      i_isg_fetch_model.send(w, 1);
      #1;
      chk("out_valid", out_valid, 1'b1);
      chk("out_insn", out_insn, w);
      chk("out_exc", out_exc, e);
      chk("out_exc_unit", out_exc_unit, u);
   endtask
   task automatic wr_mode(input logic v);
      @(posedge clk_sys);
      mode_wr <= 1'b1;
      mode_wr_val <= v;
      @(posedge clk_sys);
      mode_wr <= 1'b0;
      #1;
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_rel6;
      cfg(ISG_REL6, ISG_FPU_64, 12'h360, 10'h0);
      run(ADDIU, ISG_EXC_NONE, 2'h0);
      chk("wide_mode", {st[13], st[9:4]}, 7'b1111101);
      run({ISG_OP_USREXT, 26'h0}, ISG_EXC_RI, 2'h0);
      run({ISG_OP_CP3, 26'h0}, ISG_EXC_RI, 2'h0);
      run({ISG_OP_MJUMP, 26'h0}, ISG_EXC_RI, 2'h0);
      cfg(ISG_REL6, ISG_FPU_32, 12'h360, 10'h0);
      run({ISG_OP_COP1, 26'h0}, ISG_EXC_NONE, 2'h0);
      chk("single_only", {st[13], st[9:5], st[0]}, 7'b1010000);
      cfg(ISG_REL6, ISG_FPU_64PS, 12'h360, 10'h0);
      run(ADDIU, ISG_EXC_NONE, 2'h0);
      chk("paired_err", {st[5], st[0]}, 2'b01);
   endtask
   task automatic t_no_fpu;
      cfg(ISG_REL2, ISG_FPU_NONE, 12'h361, 10'h0);
      run({ISG_OP_COP1, 26'h0}, ISG_EXC_CPU, 2'h1);
      run({ISG_OP_LWC1, 26'h0}, ISG_EXC_CPU, 2'h1);
      run(MOVCI, ISG_EXC_CPU, 2'h1);
      chk("fp_present", st[13], 1'b0);
      run({ISG_OP_USREXT, 26'h0}, ISG_EXC_NONE, 2'h0);
      run({ISG_OP_CP3, 26'h0}, ISG_EXC_RI, 2'h0);
      cfg(ISG_REL2, ISG_FPU_32, 12'h360, 10'h0);
      run(ADDIU, ISG_EXC_NONE, 2'h0);
      chk("fpu32_pre6", st[0], 1'b1);
   endtask
   task automatic t_mode;
      cfg(ISG_REL5, ISG_FPU_64, 12'h360, 10'h0);
      run(ADDIU, ISG_EXC_NONE, 2'h0);
      wr_mode(1'b1);
      chk("mode_one", st[9], 1'b1);
      wr_mode(1'b0);
      chk("mode_zero", st[9], 1'b0);
      cfg(ISG_REL2, ISG_FPU_64, 12'h360, 10'h0);
      run(ADDIU, ISG_EXC_NONE, 2'h0);
      wr_mode(1'b1);
      chk("mode_pre5_one", st[9], 1'b1);
      wr_mode(1'b0);
      chk("mode_pre5", st[9], 1'b0);
      // Extensions on an old release strap must still lift the floor
      cfg(ISG_REL2, ISG_FPU_64, 12'he60, 10'h0);
      run(ADDIU, ISG_EXC_NONE, 2'h0);
      chk("ext_flags", {st[4], st[3:2]}, 3'b111);
   endtask
   task automatic t_cp2_dbg;
      cfg(ISG_REL2, ISG_FPU_64, 12'h160, 10'h0);
      run({ISG_OP_CP2, 26'h0}, ISG_EXC_CPU, 2'h2);
      chk("cp2_present", st[12], 1'b0);
      cfg(ISG_REL2, ISG_FPU_64, 12'h2b0, 10'h020);
      run({ISG_OP_LWC2, 26'h0}, ISG_EXC_RI, 2'h0);
      run(DBG_RETURN, ISG_EXC_RI, 2'h0);
      run(DBG_BREAK, ISG_EXC_RI, 2'h0);
      run({ISG_OP_MJUMP, 26'h0}, ISG_EXC_NONE, 2'h0);
      chk("caches_dbg", {st[12:10], st[1]}, 4'b1010);
      cfg(ISG_REL2, ISG_FPU_64, 12'h364, 10'h0);
      run({ISG_OP_LWC2, 26'h0}, ISG_EXC_NONE, 2'h0);
      run(DBG_RETURN, ISG_EXC_NONE, 2'h0);
      run(DBG_BREAK, ISG_EXC_NONE, 2'h0);
      run({ISG_OP_MJUMP, 26'h0}, ISG_EXC_RI, 2'h0);
      cfg(ISG_REL2, ISG_FPU_64, 12'h374, 10'h0);
      run(ADDIU, ISG_EXC_NONE, 2'h0);
      chk("width_clash", st[0], 1'b1);
   endtask
   // Enable low must hold status and mode against straps and writes
   task automatic t_freeze;
      @(posedge clk_sys);
      ce <= 1'b0;
      cfg(ISG_REL2, ISG_FPU_NONE, 12'h360, 10'h0);
      wr_mode(1'b1);
      chk("frozen", {st[13], st[9]}, 2'b10);
      @(posedge clk_sys);
      ce <= 1'b1;
      run({ISG_OP_COP1, 26'h0}, ISG_EXC_CPU, 2'h1);
      chk("thawed", {st[13], st[9]}, 2'b00);
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      mode_wr = 1'b0;
      mode_wr_val = 1'b0;
      fl = 12'h360;
      cfg_release = ISG_REL6;
      cfg_fpu = ISG_FPU_64;
      cfg_cp2_omit = 10'h0;
      num_errors = 0;
      total_checks = 0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      t_rel6();
      t_no_fpu();
      t_mode();
      t_cp2_dbg();
      t_freeze();
      complete_run();
   end
endmodule
`default_nettype wire
